// ---- logic/sxip_ctrl.sv ----
// Execute-in-place mode control of a multi-line serial flash read port.
// Assumes a host drives select and serial clock; config bits arrive as ports.
// What this block does
// - Cleared config bit plus low keep enters
// - In XIP, transfers start with address
// - Keep high exit sets config bit three
// - Basic variant enters on any keep low
// - Boot setting powers up already in XIP
// - Keep bit sampled on line zero
// - Keep zero stays, keep one exits
// - Other lines ignored in first dummy cycle
// - Reset pin low pulse ends XIP
// - Reset pin acts only while deselected
// - Forced exit leaves XIP and sets config bit three, no reset
// - Reset enable then reset memory resets
// - Software reset restores volatile config defaults
`include "sxip_defines.svh"
`timescale 1ns/1ps
`default_nettype none
module sxip_ctrl #(
  parameter int DUMMY_CLKS = 8,
  parameter bit BASIC_XIP  = 1'b0,
  parameter bit RESET_PIN  = 1'b1
) (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        link_clk_i,
  input  wire logic        select_n_i,
  input  wire logic [3:0]  serial_line_i,
  input  wire logic        reset_pin_n_i,
  input  wire logic [2:0]  nv_xip_cfg_i,
  input  wire logic        vcfg_xip_clear_i,
  input  wire logic        fast_read_cmd_i,
  output logic             xip_active_o,
  output logic             vcfg_xip_bit_o,
  output logic             cmd_valid_o,
  output logic [7:0]       cmd_code_o,
  output logic             addr_valid_o,
  output logic [23:0]      addr_o,
  output logic             soft_reset_o
);
  initial begin
    if (DUMMY_CLKS < 1 || DUMMY_CLKS > 15) $error("DUMMY_CLKS out of range");
  end

  // Link-domain state. The serial clock stops between frames, so every
  // frame-level reset is taken from select going high (async to link clock).
  sxip_pkg::sxip_state_e state;
  logic [4:0]  bit_cnt;
  logic [23:0] shift;
  logic        xip;
  logic        vcfg3;
  logic        rst_en_armed;
  logic        frame_tgl;
  logic        sw_rst_tgl;
  logic        frame_has_cmd;
  logic [7:0]  cmd_code;
  logic [23:0] addr;
  logic        line0_run;
  logic [4:0]  line0_cnt;
  logic        boot_done;

  function automatic sxip_pkg::sxip_proto_e proto_of(input logic [2:0] nv);
    case (nv)
      `SXIP_NVCFG_XIP_QUAD: proto_of = sxip_pkg::SXIP_PROTO_QUAD;
      `SXIP_NVCFG_XIP_DUAL: proto_of = sxip_pkg::SXIP_PROTO_DUAL;
      default:              proto_of = sxip_pkg::SXIP_PROTO_EXT;
    endcase
  endfunction

  function automatic logic [4:0] bits_per_clk(input sxip_pkg::sxip_proto_e p);
    case (p)
      sxip_pkg::SXIP_PROTO_QUAD: bits_per_clk = 5'h04;
      sxip_pkg::SXIP_PROTO_DUAL: bits_per_clk = 5'h02;
      default:                   bits_per_clk = 5'h01;
    endcase
  endfunction

  sxip_pkg::sxip_proto_e proto;
  assign proto = proto_of(nv_xip_cfg_i);

  logic [4:0] step;
  assign step = bits_per_clk(proto);

  logic [23:0] next_shift;
  always_comb begin
    case (proto)
      sxip_pkg::SXIP_PROTO_QUAD: next_shift = {shift[19:0], serial_line_i};
      sxip_pkg::SXIP_PROTO_DUAL: next_shift = {shift[21:0], serial_line_i[1:0]};
      default:                   next_shift = {shift[22:0], serial_line_i[0]};
    endcase
  end

  logic [4:0] exit_clks;
  always_comb begin
    case (proto)
      sxip_pkg::SXIP_PROTO_QUAD: exit_clks = 5'(`SXIP_EXIT_CLKS_QUAD);
      sxip_pkg::SXIP_PROTO_DUAL: exit_clks = 5'(`SXIP_EXIT_CLKS_DUAL);
      default:                   exit_clks = 5'(`SXIP_EXIT_CLKS_EXT);
    endcase
  end

  // A deasserted select or a device reset ends the frame.
  logic frame_rst;
  assign frame_rst = select_n_i | rst_i;

  logic boot_xip;
  assign boot_xip = (nv_xip_cfg_i != `SXIP_NVCFG_XIP_OFF);

  // The boot setting must already govern the first frame after reset, whose
  // first link edge is the one that loads it into the mode flag.
  logic xip_now;
  assign xip_now = boot_done ? xip : boot_xip;

  // The reset pin only counts while the device is deselected.
  logic pin_reset;
  assign pin_reset = RESET_PIN && !reset_pin_n_i && select_n_i;

  always_ff @(posedge link_clk_i or posedge frame_rst) begin
    if (frame_rst) begin
      state    <= sxip_pkg::SXIP_ST_CMD;
      bit_cnt  <= 5'h00;
      shift    <= 24'h000000;
      line0_run <= 1'b1;
      line0_cnt <= 5'h00;
      frame_has_cmd <= 1'b0;
    end else begin
      shift     <= next_shift;
      line0_run <= line0_run & serial_line_i[0];
      if (line0_cnt != 5'h1F) begin
        line0_cnt <= line0_cnt + 5'h01;
      end
      case (state)
        sxip_pkg::SXIP_ST_CMD: begin
          if (xip_now) begin
            // No command phase while in XIP; address starts right away.
            state   <= sxip_pkg::SXIP_ST_ADDR;
            bit_cnt <= step;
          end else if (bit_cnt + step >= 5'h08) begin
            state   <= fast_read_cmd_i ? sxip_pkg::SXIP_ST_ADDR : sxip_pkg::SXIP_ST_IGNORE;
            frame_has_cmd <= 1'b1;
            bit_cnt <= 5'h00;
          end else begin
            bit_cnt <= bit_cnt + step;
          end
        end
        sxip_pkg::SXIP_ST_ADDR: begin
          if (bit_cnt + step >= 5'(`SXIP_ADDR_BITS)) begin
            state   <= sxip_pkg::SXIP_ST_KEEP;
            bit_cnt <= 5'h00;
          end else begin
            bit_cnt <= bit_cnt + step;
          end
        end
        sxip_pkg::SXIP_ST_KEEP: begin
          state   <= sxip_pkg::SXIP_ST_DATA;
          bit_cnt <= 5'h01;
        end
        sxip_pkg::SXIP_ST_DATA: begin
          if (bit_cnt < 5'(DUMMY_CLKS)) begin
            bit_cnt <= bit_cnt + 5'h01;
          end
        end
        default: state <= sxip_pkg::SXIP_ST_IGNORE;
      endcase
    end
  end

  // Captured command code for reset sequencing; held until the next command phase.
  always_ff @(posedge link_clk_i or posedge rst_i) begin
    if (rst_i) begin
      cmd_code <= 8'h00;
      addr     <= 24'h000000;
    end else begin
      if (state == sxip_pkg::SXIP_ST_CMD && !xip_now && bit_cnt + step >= 5'h08) begin
        cmd_code <= next_shift[7:0];
      end
      if (state == sxip_pkg::SXIP_ST_ADDR && bit_cnt + step >= 5'(`SXIP_ADDR_BITS)) begin
        addr <= next_shift;
      end
    end
  end

  // Keep bit: only line 0 matters in the first dummy cycle.
  logic keep_sample;
  assign keep_sample = (state == sxip_pkg::SXIP_ST_KEEP) && !select_n_i;
  logic keep_bit;
  assign keep_bit = serial_line_i[0];

  // Forced exit: line 0 held high for the full count, then one more link edge while still selected.
  logic forced_exit;
  assign forced_exit = line0_run && (line0_cnt == exit_clks);

  // The XIP state and the volatile bit change on link clock edges, or at once on a pin or device reset.
  logic boot_latch;
  always_ff @(posedge link_clk_i or posedge rst_i) begin
    if (rst_i) begin
      boot_latch <= 1'b0;
    end else begin
      boot_latch <= 1'b1;
    end
  end

  // The frame flag is cleared by select going high, so it is kept here for
  // the system side, which only looks after the frame toggle has crossed.
  logic frame_cmd_seen;
  always_ff @(posedge select_n_i or posedge rst_i) begin
    if (rst_i) begin
      frame_tgl      <= 1'b0;
      sw_rst_tgl     <= 1'b0;
      rst_en_armed   <= 1'b0;
      frame_cmd_seen <= 1'b0;
    end else begin
      frame_tgl      <= ~frame_tgl;
      frame_cmd_seen <= frame_has_cmd;
      if (frame_has_cmd && cmd_code == `SXIP_CMD_RESET_EN) begin
        rst_en_armed <= 1'b1;
      end else if (frame_has_cmd && cmd_code == `SXIP_CMD_RESET_MEM && rst_en_armed) begin
        rst_en_armed <= 1'b0;
        sw_rst_tgl   <= ~sw_rst_tgl;
      end else begin
        rst_en_armed <= 1'b0;
      end
    end
  end

  // Software reset crossing: toggle seen in system domain drives soft reset out.
  logic [2:0] sw_sync;
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      sw_sync <= 3'h0;
    end else begin
      sw_sync <= {sw_sync[1:0], sw_rst_tgl};
    end
  end
  logic sw_rst_pulse;
  assign sw_rst_pulse = sw_sync[2] ^ sw_sync[1];

  // XIP and the volatile enable bit live on the link clock. Pin reset, software reset
  // and boot default set the bit to 1; pin reset clears XIP until the next link edge, and all three load the boot setting. Forced exit is taken on
  // the link edge after the line 0 counter reaches exit_clks.
  logic sw_rst_seen;
  logic [1:0] sw_link_sync;
  always_ff @(posedge link_clk_i or posedge rst_i) begin
    if (rst_i) begin
      sw_link_sync <= 2'h0;
      sw_rst_seen  <= 1'b0;
    end else begin
      sw_link_sync <= {sw_link_sync[0], sw_rst_tgl};
      sw_rst_seen  <= sw_link_sync[1];
    end
  end

  logic xip_clear;
  assign xip_clear = rst_i | pin_reset;

  always_ff @(posedge link_clk_i or posedge xip_clear) begin
    if (xip_clear) begin
      xip   <= 1'b0;
      vcfg3 <= 1'b1;
      boot_done <= 1'b0;
    end else begin
      if (!boot_done) begin
        boot_done <= 1'b1;
        xip       <= boot_xip;
        vcfg3     <= 1'b1;
      end else if (sw_rst_seen != sw_link_sync[1]) begin
        xip   <= boot_xip;
        vcfg3 <= 1'b1;
      end else if (keep_sample) begin
        if (!keep_bit && (xip || BASIC_XIP || !vcfg3)) begin
          xip <= 1'b1;
        end else if (keep_bit && xip) begin
          xip   <= 1'b0;
          vcfg3 <= 1'b1;
        end
      end else if (xip && forced_exit && state != sxip_pkg::SXIP_ST_KEEP) begin
        xip   <= 1'b0;
        vcfg3 <= 1'b1;
      end else if (vcfg_xip_clear_i) begin
        vcfg3 <= 1'b0;
      end
    end
  end

  // System-side views of link state through two-stage synchronisers.
  logic [1:0] xip_sync;
  logic [1:0] v3_sync;
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      xip_sync <= 2'h0;
      v3_sync  <= 2'h3;
    end else begin
      xip_sync <= {xip_sync[0], xip};
      v3_sync  <= {v3_sync[0], vcfg3};
    end
  end

  logic [2:0] fr_sync;
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      fr_sync <= 3'h0;
    end else begin
      fr_sync <= {fr_sync[1:0], frame_tgl};
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      xip_active_o   <= 1'b0;
      vcfg_xip_bit_o <= 1'b1;
      cmd_valid_o    <= 1'b0;
      cmd_code_o     <= 8'h00;
      addr_valid_o   <= 1'b0;
      addr_o         <= 24'h000000;
      soft_reset_o   <= 1'b0;
    end else begin
      xip_active_o   <= xip_sync[1];
      vcfg_xip_bit_o <= v3_sync[1];
      soft_reset_o   <= sw_rst_pulse;
      cmd_valid_o    <= (fr_sync[2] ^ fr_sync[1]) && frame_cmd_seen;
      addr_valid_o   <= (fr_sync[2] ^ fr_sync[1]);
      if (fr_sync[2] ^ fr_sync[1]) begin
        cmd_code_o <= cmd_code;
        addr_o     <= addr;
      end
    end
  end

  property p_keep_exit;
    @(posedge link_clk_i) disable iff (rst_i)
      (keep_sample && keep_bit && xip && boot_done && !pin_reset
       && sw_rst_seen == sw_link_sync[1]) |=> (!xip && vcfg3);
  endproperty
  a_keep_exit: assert property (p_keep_exit) else $error("keep high did not exit");

  property p_keep_stay;
    @(posedge link_clk_i) disable iff (rst_i)
      (keep_sample && !keep_bit && xip && boot_done && !pin_reset
       && sw_rst_seen == sw_link_sync[1]) |=> xip;
  endproperty
  a_keep_stay: assert property (p_keep_stay) else $error("keep low dropped xip");

  property p_xip_no_cmd;
    @(posedge link_clk_i) disable iff (frame_rst)
      (state == sxip_pkg::SXIP_ST_CMD && xip_now) |=> state == sxip_pkg::SXIP_ST_ADDR;
  endproperty
  a_xip_no_cmd: assert property (p_xip_no_cmd) else $error("xip frame took a command");

  property p_sync_out;
    @(posedge clk_i) disable iff (rst_i)
      $rose(xip_sync[1]) |=> xip_active_o;
  endproperty
  a_sync_out: assert property (p_sync_out) else $error("xip status lost");

  property p_enter;
    @(posedge link_clk_i) disable iff (rst_i)
      (keep_sample && !keep_bit && !xip && !vcfg3 && boot_done && !pin_reset
       && sw_rst_seen == sw_link_sync[1]) |=> xip;
  endproperty
  a_enter: assert property (p_enter) else $error("xip entry missed");

  property p_pin;
    @(posedge clk_i) pin_reset |-> ##[1:2] !xip;
  endproperty
  a_pin: assert property (p_pin) else $error("reset pin left xip on");

  property p_soft;
    @(posedge clk_i) disable iff (rst_i)
      soft_reset_o |-> $past(sw_rst_pulse);
  endproperty
  a_soft: assert property (p_soft) else $error("soft reset without cause");

  property p_v3;
    @(posedge link_clk_i) disable iff (rst_i)
      $fell(xip) |-> vcfg3;
  endproperty
  a_v3: assert property (p_v3) else $error("volatile bit state bad");
endmodule // sxip_ctrl
`default_nettype wire

// ---- logic/sxip_defines.svh ----
// Constants for the execute-in-place control block of the serial flash.
// Assumes inclusion by bare name from the design file.
`ifndef SXIP_DEFINES_SVH
`define SXIP_DEFINES_SVH
`define SXIP_VCFG_XIP_BIT     3
`define SXIP_NVCFG_XIP_MSB    11
`define SXIP_NVCFG_XIP_LSB    9
`define SXIP_NVCFG_XIP_OFF    3'h7
`define SXIP_NVCFG_XIP_QUAD   3'h0
`define SXIP_NVCFG_XIP_DUAL   3'h1
`define SXIP_CMD_RESET_EN     8'h66
`define SXIP_CMD_RESET_MEM    8'h99
`define SXIP_ADDR_BITS        24
`define SXIP_EXIT_CLKS_QUAD   7
`define SXIP_EXIT_CLKS_DUAL   13
`define SXIP_EXIT_CLKS_EXT    25
`endif

// ---- logic/sxip_pkg.sv ----
// Types shared by the execute-in-place control block.
// Assumes nothing of its surroundings.
package sxip_pkg;
  typedef enum logic [1:0] {
    SXIP_PROTO_EXT,
    SXIP_PROTO_DUAL,
    SXIP_PROTO_QUAD
  } sxip_proto_e;
  typedef enum logic [2:0] {
    SXIP_ST_CMD,
    SXIP_ST_ADDR,
    SXIP_ST_KEEP,
    SXIP_ST_DATA,
    SXIP_ST_IGNORE
  } sxip_state_e;
endpackage

// ---- tb/sxip_ctrl_tb.sv ----
// Bench for the execute-in-place control: host frames in, mode levels checked.
// Assumes the host model is the only driver of select, link clock and lines.
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin num_errors++; \
  $display("BAD %s exp %0h got %0h", nm, e, g); end end
module sxip_ctrl_tb;
  logic        clk, rst, pin_n, vclr, fast, sel_n, lclk;
  logic        xip, vbit, cval, aval, srst;
  logic [3:0]  line;
  logic [2:0]  nv;
  logic [7:0]  code;
  logic [23:0] addr;
  int          num_errors, n_compared, n_cmd, n_srst, cyc;

  sxip_ctrl #(.DUMMY_CLKS(8), .BASIC_XIP(1'b0), .RESET_PIN(1'b1)) i_sxip_ctrl (
    .clk_i(clk), .rst_i(rst), .link_clk_i(lclk), .select_n_i(sel_n),
    .serial_line_i(line), .reset_pin_n_i(pin_n), .nv_xip_cfg_i(nv),
    .vcfg_xip_clear_i(vclr), .fast_read_cmd_i(fast), .xip_active_o(xip),
    .vcfg_xip_bit_o(vbit), .cmd_valid_o(cval), .cmd_code_o(code),
    .addr_valid_o(aval), .addr_o(addr), .soft_reset_o(srst));
  sxip_host_model i_sxip_host_model (.select_n_o(sel_n), .link_clk_o(lclk), .line_o(line));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic print_verdict();
    if (num_errors == 0 && n_compared > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // Pulses last one cycle, so they are counted here rather than polled.
  always @(posedge clk) begin
    cyc++;
    if (cval === 1'b1) n_cmd++;
    if (srst === 1'b1) n_srst++;
    if (cyc == 20000) begin
      num_errors++;
      print_verdict();
    end
  end

  task automatic boot(input logic [2:0] cfg);
    @(negedge clk);
    nv = cfg;
    rst = 1'b1;
    repeat (20) @(negedge clk);
    rst = 1'b0;
  endtask

  task automatic go(input int w, input int n, input logic [127:0] v);
    i_sxip_host_model.send(w, n, v);
    repeat (10) @(negedge clk);
  endtask

  // Every read carries eight dummy edges, the first holding the keep bit.
  function automatic logic [127:0] ext_rd(input logic [23:0] a, input logic k);
    return {8'h0B, a, k, 7'h7F, 8'hA5, 80'h0};
  endfunction

  function automatic logic [127:0] xip_rd(input logic [23:0] a, input logic k);
    return {a, k, 7'h7F, 8'hA5, 88'h0};
  endfunction

  task automatic enter();
    vclr = 1'b1;
    go(1, 48, ext_rd(24'h000000, 1'b0));
    vclr = 1'b0;
  endtask

  initial begin
    rst = 1'b1;
    pin_n = 1'b1;
    vclr = 1'b0;
    fast = 1'b1;
    nv = 3'h7;
    num_errors = 0;
    n_compared = 0;
    n_cmd = 0;
    n_srst = 0;
    cyc = 0;
    boot(3'h7);
    `CHK("vbit", 1'b1, vbit)
    `CHK("xip", 1'b0, xip)
    go(1, 48, ext_rd(24'h000010, 1'b0));
    `CHK("xip", 1'b0, xip)
    `CHK("code", 8'h0B, code)
    `CHK("ncmd", 1, n_cmd)
    enter();
    `CHK("xip", 1'b1, xip)
    `CHK("vbit", 1'b0, vbit)
    go(1, 40, xip_rd(24'h123456, 1'b0));
    `CHK("addr", 24'h123456, addr)
    `CHK("ncmd", 2, n_cmd)
    `CHK("xip", 1'b1, xip)
    go(1, 40, xip_rd(24'h000020, 1'b1));
    `CHK("xip", 1'b0, xip)
    `CHK("vbit", 1'b1, vbit)
    enter();
    fork
      go(1, 40, xip_rd(24'h000030, 1'b0));
      begin
        #400 pin_n = 1'b0;
        #100 pin_n = 1'b1;
      end
    join
    `CHK("xip", 1'b1, xip)
    pin_n = 1'b0;
    repeat (10) @(negedge clk);
    pin_n = 1'b1;
    repeat (10) @(negedge clk);
    `CHK("xip", 1'b0, xip)
    enter();
    go(1, 25, {25'h1FFFFFF, 103'h0});
    `CHK("xip", 1'b0, xip)
    `CHK("nsrst", 0, n_srst)
    fast = 1'b0;
    go(1, 8, {8'h99, 120'h0});
    `CHK("nsrst", 0, n_srst)
    go(1, 8, {8'h66, 120'h0});
    go(1, 8, {8'h99, 120'h0});
    `CHK("nsrst", 1, n_srst)
    `CHK("vbit", 1'b1, vbit)
    fast = 1'b1;
    boot(3'h0);
    go(4, 16, {24'hABCDEF, 4'hE, 28'hFFFFFFF, 8'h5A, 64'h0});
    `CHK("xip", 1'b1, xip)
    `CHK("addr", 24'hABCDEF, addr)
    go(4, 7, {28'h1111111, 100'h0});
    `CHK("xip", 1'b0, xip)
    boot(3'h1);
    go(2, 24, {24'h13579B, 2'b10, 14'h3FFF, 8'h5A, 80'h0});
    `CHK("xip", 1'b1, xip)
    `CHK("addr", 24'h13579B, addr)
    go(2, 13, {26'h1555555, 102'h0});
    `CHK("xip", 1'b0, xip)
    print_verdict();
  end
endmodule // sxip_ctrl_tb
`default_nettype wire

// ---- tb/sxip_host_model.sv ----
// Host controller model that clocks frames into the serial port of the XIP block.
// Assumes the bench calls send by hierarchical reference, one frame at a time.
`timescale 1ns/1ps
`default_nettype none
module sxip_host_model (
  output logic       select_n_o,
  output logic       link_clk_o,
  output logic [3:0] line_o
);
  initial begin
    select_n_o = 1'b1;
    link_clk_o = 1'b0;
    line_o     = 4'h0;
  end
  // Bits go out MSB first, w lines per edge; the clock stands still between frames.
  // Released lines show the inverse of their last level, since nothing pulls them.
  task automatic send(input int w, input int n, input logic [127:0] v);
    select_n_o = 1'b0;
    for (int k = 0; k < n; k++) begin
      line_o = (w == 4) ? v[127:124] : (w == 2) ? {2'b00, v[127:126]} : {3'b000, v[127]};
      v = v << w;
      #24 link_clk_o = 1'b1;
      #24 link_clk_o = 1'b0;
    end
    #24 select_n_o = 1'b1;
    line_o = ~line_o;
  endtask
endmodule // sxip_host_model
`default_nettype wire
